// ===== hw/hcr_top.sv
// Purpose: Upper half of the hardware configuration register with detach control.
// Assumes: aresetn is the power-on reset; usb_reset and lite_soft_reset are pulses.
// Notes: Image inputs carry the last loaded EEPROM or OTP values.
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////
module hcr_top
  import hcr_pkg::*;
(
  // Clock and power-on reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output var  logic [1:0]        s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  // Other resets
  input  wire logic              usb_reset,
  input  wire logic              lite_soft_reset,
  // Image and environment
  input  wire logic              eeprom_present,
  input  wire logic              otp_configured,
  input  wire logic [3:0]        img_led_on,
  input  wire logic              img_pin_buf,
  input  wire logic              img_pin_en,
  input  wire logic              img_pin_pol,
  input  wire logic              hsic_mode,
  // USB core and wake sources
  input  wire logic              usb_attaching,
  input  wire logic              usb_attached,
  input  wire logic              phy_link_up,
  input  wire logic              gpio_wake,
  // Outputs
  output var  logic [3:0]        led_pin_function_on,
  output var  logic              descriptor_from_ram,
  output var  logic              usb_detach,
  output var  logic              attach_pin_o,
  output var  logic              attach_pin_oe,
  output var  logic              irq
);
  typedef struct packed {
    hcr_det_t          det;
    logic [3:0]        led;
    logic              flag;
    logic              req;
    logic              sel;
    logic              prot;
    logic              pin_buf;
    logic              pin_en;
    logic              pin_pol;
    logic              loaded;
    logic              irq_sts;
    logic              irq_msk;
    logic              irq;
    logic              desc_ram;
    logic              detached;
    logic              wr_cfg;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } hcr_st_t;

  hcr_st_t s_q;
  hcr_st_t s_d;
  logic    other_rst;
  logic    wr_hi;
  logic    wr_lo;
  logic    wr_led;

  function automatic logic [31:0] cfg_word(input hcr_st_t s);
    logic [31:0] w;
    w                  = 32'h00000000;
    w[POS_LED+:4]      = s.led;
    w[POS_FLAG]        = s.flag;
    w[POS_REQ]         = s.req;
    w[POS_SEL]         = s.sel;
    w[POS_PROT]        = s.prot;
    w[POS_PIN_BUF]     = s.pin_buf;
    w[POS_PIN_EN]      = s.pin_en;
    w[POS_PIN_POL]     = s.pin_pol;
    return w & ~CFG_RSVD_MASK;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d        = s_q;
    s_d.wr_cfg = 1'b0;
    other_rst  = usb_reset || lite_soft_reset;
    wr_hi      = s_q.w_strb[1];
    wr_lo      = s_q.w_strb[0];
    wr_led     = s_q.w_strb[2];

    if (!s_q.loaded) begin
      s_d.loaded  = 1'b1;
      s_d.led     = img_led_on;
      s_d.pin_buf = img_pin_buf;
      s_d.pin_en  = img_pin_en;
      s_d.pin_pol = img_pin_pol;
    end

    // Write channel: address and data are taken independently.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      unique case ({s_q.aw_addr[ADDR_W-1:2], 2'b00})
        OFF_CONFIG: begin
          s_d.wr_cfg = 1'b1;
          if (wr_led) begin
            s_d.led = s_q.w_data[POS_LED+:4];
          end
          if (wr_hi) begin
            if (s_q.w_data[POS_FLAG]) begin
              s_d.flag = 1'b0;
            end
            if (s_q.w_data[POS_REQ]) begin
              s_d.req = 1'b1;
            end
            s_d.sel  = s_q.w_data[POS_SEL];
            s_d.prot = s_q.w_data[POS_PROT];
            s_d.pin_buf = s_q.w_data[POS_PIN_BUF];
            s_d.pin_en  = s_q.w_data[POS_PIN_EN];
            s_d.pin_pol = s_q.w_data[POS_PIN_POL];
          end
        end
        OFF_IRQ_STS: begin
          if (wr_lo && s_q.w_data[POS_IRQ_REATT]) begin
            s_d.irq_sts = 1'b0;
          end
        end
        OFF_IRQ_MSK: begin
          if (wr_lo) begin
            s_d.irq_msk = s_q.w_data[POS_IRQ_REATT];
          end
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (s_q.loaded && other_rst && !s_q.prot) begin
      s_d.led     = img_led_on;
      s_d.sel     = RST_SEL;
      s_d.prot    = RST_PROT;
      s_d.pin_buf = img_pin_buf;
      s_d.pin_en  = img_pin_en;
      s_d.pin_pol = img_pin_pol;
    end

    // Detach sequence; the set of the flag comes last so it beats a clear.
    unique case (s_q.det)
      DET_ATTACHED: begin
        if (s_q.req) begin
          s_d.det = DET_DETACHED;
        end
      end
      DET_DETACHED: begin
        if (phy_link_up || gpio_wake) begin
          s_d.det = DET_REATTACH;
        end
      end
      DET_REATTACH: begin
        if (usb_attached) begin
          s_d.det     = DET_ATTACHED;
          s_d.req     = 1'b0;
          s_d.flag    = 1'b1;
          s_d.irq_sts = 1'b1;
        end
      end
    endcase
    s_d.detached = (s_d.det == DET_DETACHED);

    s_d.desc_ram = s_d.sel && !eeprom_present && !otp_configured;
    s_d.irq      = s_d.irq_sts && s_d.irq_msk;

    // Read channel; one read is served at a time.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFF_CONFIG:  s_d.rdata = cfg_word(s_q);
        OFF_IRQ_STS: s_d.rdata = {31'h00000000, s_q.irq_sts};
        OFF_IRQ_MSK: s_d.rdata = {31'h00000000, s_q.irq_msk};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reattach indication
  hcr_attach_pin u_pin (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .pin_push_pull          (s_q.pin_buf),
    .pin_enable             (s_q.pin_en),
    .attach_pin_level_sense (s_q.pin_pol),
    .hsic_mode              (hsic_mode),
    .attempting             (usb_attaching || (s_q.det == DET_REATTACH)),
    .pin_o                  (attach_pin_o),
    .pin_oe                 (attach_pin_oe)
  );

  assign s_axi_awready       = s_q.awready;
  assign s_axi_wready        = s_q.wready;
  assign s_axi_bvalid        = s_q.bvalid;
  assign s_axi_bresp         = s_q.bresp;
  assign s_axi_arready       = s_q.arready;
  assign s_axi_rvalid        = s_q.rvalid;
  assign s_axi_rdata         = s_q.rdata;
  assign s_axi_rresp         = s_q.rresp;
  assign led_pin_function_on = s_q.led;
  assign descriptor_from_ram = s_q.desc_ram;
  assign usb_detach          = s_q.detached;
  assign irq                 = s_q.irq;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_led;
    s_q.wr_cfg && s_q.w_strb[2] && !$past(other_rst)
      |-> led_pin_function_on == s_q.w_data[23:20];
  endproperty
  a_led: assert property (p_led) else $error("LED enables differ from write");

  property p_prot;
    other_rst && s_q.prot && s_q.loaded && !s_q.wr_cfg && !(s_q.aw_have && s_q.w_have)
      |=> $stable(s_q.led) && $stable(s_q.pin_en) && s_q.prot;
  endproperty
  a_prot: assert property (p_prot) else $error("Protected field lost on reset");

  property p_flag;
    s_q.det == DET_REATTACH && usb_attached |=> s_q.flag && s_q.irq_sts;
  endproperty
  a_flag: assert property (p_flag) else $error("Detach flag not set on reattach");

  property p_detach;
    s_q.wr_cfg && s_q.w_strb[1] && s_q.w_data[14] && s_q.det == DET_ATTACHED
      |=> usb_detach;
  endproperty
  a_detach: assert property (p_detach) else $error("No detach after request");

  property p_stay;
    usb_detach && !phy_link_up && !gpio_wake |=> usb_detach;
  endproperty
  a_stay: assert property (p_stay) else $error("Left detach without wake");

  property p_desc;
    eeprom_present || otp_configured |=> !descriptor_from_ram;
  endproperty
  a_desc: assert property (p_desc) else $error("Descriptor select not ignored");

  property p_hsic;
    !hsic_mode |=> !attach_pin_oe;
  endproperty
  a_hsic: assert property (p_hsic) else $error("Attach pin driven outside HSIC");

  property p_rsvd;
    $rose(s_axi_rvalid) |-> (s_axi_rdata & CFG_RSVD_MASK) == 32'h00000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved bits read nonzero");

  property p_pin;
    s_q.det == DET_REATTACH && s_q.pin_en && s_q.pin_buf && hsic_mode
      |=> attach_pin_oe && attach_pin_o == $past(s_q.pin_pol);
  endproperty
  a_pin: assert property (p_pin) else $error("Attach pin not asserted");

  property p_irq;
    irq == (s_q.irq_sts && s_q.irq_msk);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt output mismatch");

  c_detach: cover property (s_q.det == DET_DETACHED ##1 s_q.det == DET_REATTACH);
  c_reatt:  cover property (s_q.det == DET_REATTACH ##1 s_q.det == DET_ATTACHED);
  c_wr:     cover property (s_axi_bvalid && s_axi_bready);
  c_irq:    cover property ($rose(irq));
endmodule // hcr_top
`default_nettype wire

// ===== hw/hcr_pkg.sv
// Purpose: Shared constants and types of the hardware configuration register block.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses.
package hcr_pkg;
  localparam int unsigned    ADDR_W        = 8;
  localparam logic [7:0]     OFF_CONFIG    = 8'h10;
  localparam logic [7:0]     OFF_IRQ_STS   = 8'h14;
  localparam logic [7:0]     OFF_IRQ_MSK   = 8'h18;
  // Field positions inside hardware_configuration.
  localparam int unsigned    POS_LED       = 20;
  localparam int unsigned    POS_FLAG      = 15;
  localparam int unsigned    POS_REQ       = 14;
  localparam int unsigned    POS_SEL       = 13;
  localparam int unsigned    POS_PROT      = 12;
  localparam int unsigned    POS_PIN_BUF   = 10;
  localparam int unsigned    POS_PIN_EN    = 9;
  localparam int unsigned    POS_PIN_POL   = 8;
  localparam logic [31:0]    CFG_RSVD_MASK = 32'hff0f0800;
  // Interrupt status and mask layout.
  localparam int unsigned    POS_IRQ_REATT = 0;
  // Reset values of software-owned fields, then AXI response codes.
  localparam logic           RST_SEL       = 1'h0;
  localparam logic           RST_PROT      = 1'h0;
  localparam logic           RST_FLAG      = 1'h0;
  localparam logic [1:0]     RESP_OKAY     = 2'h0;
  localparam logic [1:0]     RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {DET_ATTACHED, DET_DETACHED, DET_REATTACH} hcr_det_t;
endpackage

// ===== hw/hcr_attach_pin.sv
// Purpose: Registered driver of the attach-indicator pin.
// Assumes: Configuration fields come from flops of the register block.
// Notes: The pin is never driven unless enabled in HSIC operation.
`timescale 1ns/1ns
`default_nettype none
module hcr_attach_pin
  import hcr_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Settings
  input  wire logic pin_push_pull,
  input  wire logic pin_enable,
  input  wire logic attach_pin_level_sense,
  input  wire logic hsic_mode,
  input  wire logic attempting,
  // Pin
  output var  logic pin_o,
  output var  logic pin_oe
);
  typedef struct packed {
    logic o;
    logic oe;
  } hcr_pin_st_t;

  hcr_pin_st_t s_q;
  hcr_pin_st_t s_d;
  logic        level;

  always_comb begin
    s_d   = s_q;
    level = attempting ? attach_pin_level_sense : ~attach_pin_level_sense;
    if (!(pin_enable && hsic_mode)) begin
      s_d.o  = 1'b0;
      s_d.oe = 1'b0;
    end else if (pin_push_pull) begin
      s_d.o  = level;
      s_d.oe = 1'b1;
    end else begin
      // Open drain can only pull low; a high level is left to the pull-up.
      s_d.o  = 1'b0;
      s_d.oe = ~level;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_o  = s_q.o;
  assign pin_oe = s_q.oe;
endmodule // hcr_attach_pin
`default_nettype wire

// ===== verification/hcr_usb_core_model.sv
// Purpose: Behavioural USB core on the far side of the detach control.
// Assumes: usb_detach is high while the block holds itself off the bus.
// Notes: Attach completes ATTACH_DLY+1 cycles after the detach ends, never at once.
`timescale 1ns/1ns
`default_nettype none
module hcr_usb_core_model #(
  parameter int ATTACH_DLY = 4
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Block side
  input  wire logic usb_detach,
  output var  logic usb_attached
);
  int cnt;

  // Enumeration takes time, so the reattach window is always several cycles long.
  always @(posedge aclk) begin
    if (!aresetn || usb_detach) begin
      cnt <= 0;
      usb_attached <= 1'b0;
    end else if (cnt < ATTACH_DLY) begin
      cnt <= cnt + 1;
    end else begin
      usb_attached <= 1'b1;
    end
  end
endmodule // hcr_usb_core_model
`default_nettype wire

// ===== verification/hcr_top_test.sv
// Purpose: Self-checking bench of the hardware configuration register block.
// Assumes: Outputs are sampled at the falling edge, where they are settled, except the LED check after rd in t_resets.
// Notes: Image inputs stay fixed, so every reset restore has a known target.
`timescale 1ns/1ns
`default_nettype none
module hcr_top_test;
  import hcr_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, usb_reset, lite_soft_reset, eeprom_present, otp_configured;
  logic        img_pin_buf, img_pin_en, img_pin_pol, hsic_mode, usb_attaching, usb_attached;
  logic        phy_link_up, gpio_wake, descriptor_from_ram, usb_detach, attach_pin_o;
  logic        attach_pin_oe, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, img_led_on, led_pin_function_on;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count, samples_checked;

  hcr_top u_hcr_top (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .usb_reset, .lite_soft_reset,
    .eeprom_present, .otp_configured, .img_led_on, .img_pin_buf, .img_pin_en, .img_pin_pol,
    .hsic_mode, .usb_attaching, .usb_attached, .phy_link_up, .gpio_wake,
    .led_pin_function_on, .descriptor_from_ram, .usb_detach, .attach_pin_o,
    .attach_pin_oe, .irq);
  hcr_usb_core_model u_hcr_usb_core_model (.aclk, .aresetn, .usb_detach, .usb_attached);

  always #20 aclk = ~aclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Ready lines stay high, so bvalid or rvalid alone marks the response edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 1'b0;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    chk(32'({hb, r}), 32'({1'b1, er}));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [33:0] v;
    hr = 1'b0;
    v = '1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !hr; n++) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      v = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    chk(v[31:0], ed);
    chk(32'({hr, v[33:32]}), 32'({1'b1, er}));
  endtask

  task automatic pulse(input int i);
    usb_reset <= (i == 0);
    lite_soft_reset <= (i == 1);
    @(posedge aclk);
    usb_reset <= 1'b0;
    lite_soft_reset <= 1'b0;
  endtask

  task automatic see(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_fields();
    rd(OFF_CONFIG, 32'h00a00500, RESP_OKAY);
    wr(OFF_CONFIG, 32'hff5fbfff, RESP_OKAY);
    rd(OFF_CONFIG, 32'h00503700, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      eeprom_present <= (i == 1);
      otp_configured <= (i == 2);
      see(3);
      chk(32'(descriptor_from_ram), 32'(i == 0));
      chk(32'(led_pin_function_on), 32'h5);
      @(posedge aclk);
    end
    eeprom_present <= 1'b0;
    otp_configured <= 1'b0;
  endtask

  task automatic t_resets();
    for (int i = 0; i < 2; i++) begin
      pulse(i);
      rd(OFF_CONFIG, 32'h00503700, RESP_OKAY);
    end
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CONFIG, 32'h00502700, RESP_OKAY);
      pulse(i);
      rd(OFF_CONFIG, 32'h00a00500, RESP_OKAY);
      chk(32'(led_pin_function_on), 32'ha);
    end
  endtask

  task automatic t_pin();
    logic lv;
    hsic_mode <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CONFIG, {21'h0, k[1], 1'b1, k[0], 8'h0}, RESP_OKAY);
      for (int a = 1; a >= 0; a--) begin
        usb_attaching <= a[0];
        see(3);
        lv = k[0] ^ !a[0];
        chk(32'({attach_pin_o, attach_pin_oe}), k[1] ? 32'({lv, 1'b1}) : 32'({1'b0, !lv}));
        @(posedge aclk);
      end
    end
    usb_attaching <= 1'b1;
    hsic_mode <= 1'b0;
    see(3);
    chk(32'({attach_pin_o, attach_pin_oe}), 32'h0);
    @(posedge aclk);
    usb_attaching <= 1'b0;
    hsic_mode <= 1'b1;
  endtask

  task automatic t_detach(input logic by_gpio);
    int n;
    wr(OFF_IRQ_MSK, 32'h1, RESP_OKAY);
    wr(OFF_CONFIG, 32'h00004700, RESP_OKAY);
    for (n = 0; n < 10 && usb_detach !== 1'b1; n++) @(negedge aclk);
    see(6);
    chk(32'(usb_detach), 32'h1);
    @(posedge aclk);
    phy_link_up <= !by_gpio;
    gpio_wake <= by_gpio;
    for (n = 0; n < 10 && usb_detach !== 1'b0; n++) @(negedge aclk);
    @(posedge aclk);
    phy_link_up <= 1'b0;
    gpio_wake <= 1'b0;
    see(1);
    chk(32'({attach_pin_o, attach_pin_oe}), 32'h3);
    for (n = 0; n < 30 && irq !== 1'b1; n++) @(negedge aclk);
    @(posedge aclk);
    rd(OFF_CONFIG, 32'h00008700, RESP_OKAY);
    rd(OFF_IRQ_STS, 32'h1, RESP_OKAY);
    wr(OFF_IRQ_MSK, 32'h0, RESP_OKAY);
    see(0);
    chk(32'(irq), 32'h0);
    @(posedge aclk);
    wr(OFF_IRQ_MSK, 32'h1, RESP_OKAY);
    see(0);
    chk(32'(irq), 32'h1);
    @(posedge aclk);
    wr(OFF_CONFIG, 32'h00008700, RESP_OKAY);
    rd(OFF_CONFIG, 32'h00000700, RESP_OKAY);
    wr(OFF_IRQ_STS, 32'h1, RESP_OKAY);
    see(0);
    chk(32'(irq), 32'h0);
    @(posedge aclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {usb_reset, lite_soft_reset, eeprom_present, otp_configured, hsic_mode} = '0;
    {usb_attaching, phy_link_up, gpio_wake, img_pin_en} = '0;
    {s_axi_bready, s_axi_rready, img_pin_buf, img_pin_pol} = '1;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    img_led_on = 4'ha;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_fields();
    t_resets();
    t_pin();
    t_detach(1'b0);
    t_detach(1'b1);
    wr(8'h40, 32'hffffffff, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    rd(OFF_CONFIG, 32'h00000700, RESP_OKAY);
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    finish_test();
  end
endmodule // hcr_top_test
`default_nettype wire
